// *** design/dcsc_pkg.sv ***
// Package: offsets, field positions, states and carriers of the channel controller
package dcsc_pkg;
	localparam logic [7:0] OFS_CMD = 8'h84;
	localparam logic [7:0] OFS_STS = 8'h88;
	localparam logic [7:0] OFS_CMPA = 8'h98;
	localparam logic [7:0] OFS_CMPB = 8'h9c;
	localparam logic [11:0] CFG_BASE_LO = 12'h010;
	localparam logic [11:0] CFG_BASE_HI = 12'h014;
	localparam int REGION_BITS = 12;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_SUSP_BIT = 2;
	localparam int CMD_RESET_BIT = 5;
	localparam int STS_ERR_BIT = 3;
	localparam int ADDR_USED = 48;
	localparam int FIFO_DEPTH = 4;
	localparam logic [63:0] BASE_RESET = 64'h0;
	localparam logic [31:0] CMP_RESET = 32'h0;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [3:0] OUTST_ZERO = 4'h0;
	localparam logic [2:0] FUNC_NUM_DEFAULT = 3'h0;

	typedef enum logic [2:0] {
		ST_ACTIVE = 3'b000,
		ST_IDLE = 3'b001,
		ST_HALT = 3'b011,
		ST_ARMED = 3'b100
	} dcsc_state_type;

	typedef struct packed {
		logic [63:0] desc_addr;
		logic [63:0] src;
		logic [63:0] dst;
		logic [63:0] chain;
		logic fence;
		logic xor_op;
		logic last;
	} dcsc_desc_type;

	typedef struct packed {
		logic [ADDR_USED-1:0] addr_a;
		logic [ADDR_USED-1:0] addr_b;
		logic xor_op;
		logic is_status;
	} dcsc_req_type;

	localparam int DESC_W = $bits(dcsc_desc_type);
endpackage

// *** design/dcsc_channel.sv ***
// Channel state control, address checking and descriptor buffering of one copy channel
// How it works
// - suspend while armed moves the channel to halted.
// - status bits 2:0 at 0x88 give the state, 000 active, 001 idle.
// - command bit 5 resets the channel, bit 2 suspends it.
// - only the low 48 address bits are ever used.
// - any address beyond 48 bits is an addressing error and halts the channel.
// - the check covers both completion registers and xor source and destination.
// - after activation the first descriptor's fence is honoured and it is kept until issued.
// - completion status is posted only after every covered descriptor completed.
// - the registers sit in a region located by the base at config offset 0x10.
`timescale 1ns/1ps
`default_nettype none

module dcsc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [PW:0] cnt_r, cnt_nxt;
	logic push, pop;

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (clr) begin
			wp_nxt = '0;
			rp_nxt = '0;
			cnt_nxt = '0;
		end else begin
			if (push)
				wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
			cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_ready <= 1'b0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			in_ready <= cnt_nxt != FULL;
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem_r[wp_r] <= in_data;
	end

	assign out_valid = cnt_r != '0;
	assign out_data = mem_r[rp_r];
endmodule

module dcsc_channel
	import dcsc_pkg::*;
#(
	parameter logic [2:0] FUNC_NUM = FUNC_NUM_DEFAULT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration space writes
	input wire logic cfg_wr,
	input wire logic [11:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	// Memory-mapped register access
	input wire logic [63:0] mmio_addr,
	input wire logic mmio_wr,
	input wire logic mmio_rd,
	input wire logic [31:0] mmio_wdata,
	output logic [31:0] mmio_rdata,
	output logic mmio_rvalid,
	// Descriptor stream in
	input wire logic desc_in_valid,
	output logic desc_in_ready,
	input wire dcsc_pkg::dcsc_desc_type desc_in,
	// Memory requests out
	output logic mem_req_valid,
	input wire logic mem_req_ready,
	output dcsc_pkg::dcsc_req_type mem_req,
	input wire logic mem_done,
	// Channel state
	output dcsc_pkg::dcsc_state_type chan_state,
	output logic chan_err
);
	import dcsc_pkg::*;

	function automatic logic too_wide(input logic [63:0] a);
		too_wide = |a[63:ADDR_USED];
	endfunction

	dcsc_state_type state_r, state_nxt;
	logic [63:0] base_r, base_nxt;
	logic [31:0] cmpa_r, cmpa_nxt, cmpb_r, cmpb_nxt, rdata_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	logic err_r, err_nxt, hold_r, hold_nxt, post_r, post_nxt, rvalid_nxt, req_v_nxt;
	logic [3:0] outst_r, outst_nxt;
	dcsc_desc_type desc_r, desc_nxt, fifo_out;
	dcsc_req_type req_nxt;
	logic hit, wr_cmd, fifo_v, fifo_rdy, fifo_clr, accept, bad_desc, bad_cmp;
	logic [63:0] cmp_addr;

	dcsc_fifo #(.WIDTH(DESC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst(rst),
		.clr(fifo_clr),
		.in_valid(desc_in_valid),
		.in_ready(desc_in_ready),
		.in_data(desc_in),
		.out_valid(fifo_v),
		.out_ready(fifo_rdy),
		.out_data(fifo_out)
	);

	always_comb begin
		hit = mmio_addr[63:REGION_BITS] == base_r[63:REGION_BITS];
		wr_cmd = mmio_wr && hit && mmio_addr[7:0] == OFS_CMD;
		cmp_addr = {cmpb_r, cmpa_r};
		bad_cmp = too_wide(cmp_addr);
		bad_desc = too_wide(desc_r.src) || too_wide(desc_r.dst) || too_wide(desc_r.chain)
			|| too_wide(desc_r.desc_addr);
		accept = mem_req_valid && mem_req_ready;
		fifo_clr = wr_cmd && mmio_wdata[CMD_RESET_BIT];
		fifo_rdy = state_r == ST_ACTIVE && !hold_r && !post_r;
		base_nxt = base_r;
		cmpa_nxt = cmpa_r;
		cmpb_nxt = cmpb_r;
		cmd_nxt = cmd_r & ~(8'h01 << CMD_START_BIT) & ~(8'h01 << CMD_SUSP_BIT) & ~(8'h01 << CMD_RESET_BIT);
		state_nxt = state_r;
		err_nxt = err_r;
		hold_nxt = hold_r;
		post_nxt = post_r;
		desc_nxt = desc_r;
		req_v_nxt = mem_req_valid && !accept;
		req_nxt = mem_req;
		outst_nxt = outst_r + 4'(accept) - 4'(mem_done);
		rvalid_nxt = mmio_rd;
		rdata_nxt = 32'h0;
		if (cfg_wr && cfg_addr == CFG_BASE_LO)
			base_nxt[31:0] = cfg_wdata;
		if (cfg_wr && cfg_addr == CFG_BASE_HI)
			base_nxt[63:32] = cfg_wdata;
		if (mmio_rd && hit) begin
			case (mmio_addr[7:0])
				OFS_CMD: rdata_nxt = {24'h0, cmd_r};
				OFS_STS: rdata_nxt = {28'h0, err_r, state_r};
				OFS_CMPA: rdata_nxt = cmpa_r;
				OFS_CMPB: rdata_nxt = cmpb_r;
				default: rdata_nxt = 32'h0;
			endcase
		end
		if (mmio_wr && hit && mmio_addr[7:0] == OFS_CMPA)
			cmpa_nxt = mmio_wdata;
		if (mmio_wr && hit && mmio_addr[7:0] == OFS_CMPB)
			cmpb_nxt = mmio_wdata;
		// Engine work while active
		if (state_r == ST_ACTIVE) begin
			if (!hold_r && fifo_v && fifo_rdy) begin
				desc_nxt = fifo_out;
				hold_nxt = 1'b1;
			end
			if (hold_r && !mem_req_valid) begin
				if (bad_desc || bad_cmp) begin
					state_nxt = ST_HALT;
					err_nxt = 1'b1;
					hold_nxt = 1'b0;
				end else if (!desc_r.fence || outst_r == OUTST_ZERO) begin
					req_v_nxt = 1'b1;
					req_nxt.addr_a = desc_r.src[ADDR_USED-1:0];
					req_nxt.addr_b = desc_r.dst[ADDR_USED-1:0];
					req_nxt.xor_op = desc_r.xor_op;
					req_nxt.is_status = 1'b0;
				end
			end
			if (accept && !mem_req.is_status) begin
				hold_nxt = 1'b0;
				post_nxt = desc_r.last;
			end
			if (post_r && !mem_req_valid && outst_r == OUTST_ZERO) begin
				if (bad_cmp) begin
					state_nxt = ST_HALT;
					err_nxt = 1'b1;
					post_nxt = 1'b0;
				end else begin
					req_v_nxt = 1'b1;
					req_nxt.addr_a = cmp_addr[ADDR_USED-1:0];
					req_nxt.addr_b = desc_r.desc_addr[ADDR_USED-1:0];
					req_nxt.xor_op = 1'b0;
					req_nxt.is_status = 1'b1;
				end
			end
			if (accept && mem_req.is_status) begin
				post_nxt = 1'b0;
				state_nxt = ST_IDLE;
			end
		end
		// Software commands
		if (wr_cmd) begin
			cmd_nxt = mmio_wdata[7:0];
			if (mmio_wdata[CMD_RESET_BIT]) begin
				state_nxt = ST_ARMED;
				err_nxt = 1'b0;
				hold_nxt = 1'b0;
				post_nxt = 1'b0;
				req_v_nxt = 1'b0;
			end else if (mmio_wdata[CMD_SUSP_BIT]) begin
				if (state_r != ST_HALT) begin
					state_nxt = ST_HALT;
					req_v_nxt = 1'b0;
				end
			end else if (mmio_wdata[CMD_START_BIT] && !err_r && state_r != ST_ACTIVE) begin
				state_nxt = ST_ACTIVE;
			end
		end
		if (err_nxt)
			req_v_nxt = 1'b0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_ARMED;
			base_r <= BASE_RESET;
			cmpa_r <= CMP_RESET;
			cmpb_r <= CMP_RESET;
			cmd_r <= CMD_RESET;
			err_r <= 1'b0;
			hold_r <= 1'b0;
			post_r <= 1'b0;
			desc_r <= '0;
			mem_req_valid <= 1'b0;
			mem_req <= '0;
			outst_r <= OUTST_ZERO;
			mmio_rvalid <= 1'b0;
			mmio_rdata <= 32'h0;
			chan_state <= ST_ARMED;
			chan_err <= 1'b0;
		end else begin
			state_r <= state_nxt;
			base_r <= base_nxt;
			cmpa_r <= cmpa_nxt;
			cmpb_r <= cmpb_nxt;
			cmd_r <= cmd_nxt;
			err_r <= err_nxt;
			hold_r <= hold_nxt;
			post_r <= post_nxt;
			desc_r <= desc_nxt;
			mem_req_valid <= req_v_nxt;
			mem_req <= req_nxt;
			outst_r <= outst_nxt;
			mmio_rvalid <= rvalid_nxt;
			mmio_rdata <= rdata_nxt;
			chan_state <= state_nxt;
			chan_err <= err_nxt;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_susp_to_halt: assert property (wr_cmd && mmio_wdata[CMD_SUSP_BIT] && !mmio_wdata[CMD_RESET_BIT]
		&& state_r == ST_ARMED |=> state_r == ST_HALT && !mem_req_valid)
		else $error("suspend while armed did not halt");
	a_status_code: assert property (mmio_rd && hit && mmio_addr[7:0] == OFS_STS
		|=> mmio_rvalid && mmio_rdata[2:0] == $past(state_r) && mmio_rdata[31:4] == 28'h0)
		else $error("status read does not show state");
	a_reset_arms: assert property (fifo_clr |=> state_r == ST_ARMED && !err_r && !mem_req_valid
		&& desc_in_ready)
		else $error("channel reset did not arm");
	a_err_halts: assert property (state_r == ST_ACTIVE && hold_r && !mem_req_valid && bad_desc && !wr_cmd
		|=> state_r == ST_HALT && err_r)
		else $error("wide address did not halt");
	a_cmp_check: assert property (state_r == ST_ACTIVE && post_r && !mem_req_valid && outst_r == OUTST_ZERO
		&& bad_cmp && !wr_cmd |=> err_r && !mem_req_valid)
		else $error("wide completion address not flagged");
	a_err_quiet: assert property (err_r && !fifo_clr |=> !mem_req_valid [*2])
		else $error("request issued after addressing error");
	a_fence_wait: assert property (state_r == ST_ACTIVE && hold_r && desc_r.fence && outst_r != OUTST_ZERO
		&& !mem_req_valid |=> !mem_req_valid)
		else $error("fenced descriptor issued early");
	a_post_done: assert property (mem_req_valid && mem_req.is_status |-> outst_r == OUTST_ZERO
		&& !hold_r)
		else $error("completion posted before copies done");
	a_low_bits: assert property (mem_req_valid && !mem_req.is_status
		|-> mem_req.addr_a == desc_r.src[ADDR_USED-1:0] && !too_wide(desc_r.src))
		else $error("request address not from low bits");
	a_region_miss: assert property (mmio_rd && !hit |=> mmio_rdata == 32'h0)
		else $error("read outside region answered");

	c_err_halt: cover property (state_r == ST_ACTIVE ##1 state_r == ST_HALT && err_r);
	c_status_post: cover property (accept && mem_req.is_status);
	c_susp_armed: cover property (state_r == ST_ARMED ##1 state_r == ST_HALT);
	c_fifo_full: cover property (!desc_in_ready && state_r == ST_ACTIVE);
endmodule

`default_nettype wire

// *** verification/dcsc_mem_model.sv ***
// Memory side model: stalls every other cycle and completes each request four cycles later
`timescale 1ns/1ps
`default_nettype none
module dcsc_mem_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Request handshake
	input wire logic req_valid,
	output logic req_ready,
	output logic done
);
	logic tick_r, tick_nxt;
	logic [3:0] pipe_r, pipe_nxt;
	always_comb begin
		tick_nxt = ~tick_r;
		pipe_nxt = {pipe_r[2:0], req_valid && req_ready};
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_r <= 1'b0;
			pipe_r <= 4'h0;
		end else begin
			tick_r <= tick_nxt;
			pipe_r <= pipe_nxt;
		end
	end
	assign req_ready = tick_r;
	assign done = pipe_r[3];
endmodule
`default_nettype wire

// *** verification/dma_channel_state_control_tb.sv ***
// Testbench of the channel controller: register, descriptor and error scenarios
`timescale 1ns/1ps
`default_nettype none
module dma_channel_state_control_tb;
	import dcsc_pkg::*;
	localparam logic [63:0] B = 64'h1000;
	logic clk, rst, cfg_wr, mmio_wr, mmio_rd, dv, dr, rv, mv, mrdy, mdone, cerr;
	logic [11:0] ca;
	logic [31:0] cd, wd, rdat;
	logic [63:0] ma;
	logic [47:0] last_a, last_b;
	dcsc_desc_type din;
	dcsc_req_type mq;
	dcsc_state_type st;
	int n_mismatch, samples_checked, n_acc, n_done, n_stat, n_bad, snap, i;
	dcsc_channel DUT (.clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_addr(ca), .cfg_wdata(cd),
		.mmio_addr(ma), .mmio_wr(mmio_wr), .mmio_rd(mmio_rd), .mmio_wdata(wd), .mmio_rdata(rdat),
		.mmio_rvalid(rv), .desc_in_valid(dv), .desc_in_ready(dr), .desc_in(din), .mem_req_valid(mv),
		.mem_req_ready(mrdy), .mem_req(mq), .mem_done(mdone), .chan_state(st), .chan_err(cerr));
	dcsc_mem_model MEM (.clk(clk), .rst(rst), .req_valid(mv), .req_ready(mrdy), .done(mdone));
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (mdone)
			n_done++;
		if (mv && mrdy) begin
			if ((mq.is_status || mq.addr_a == 48'h4200) && n_acc != n_done)
				n_bad++;
			if (mq.is_status)
				n_stat++;
			if (mq.is_status) begin
				last_a = mq.addr_a;
				last_b = mq.addr_b;
			end
			n_acc++;
		end
	end
	task chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] o, input logic [31:0] d);
		@(negedge clk);
		ma = B + o;
		wd = d;
		mmio_wr = 1;
		@(negedge clk);
		mmio_wr = 0;
	endtask
	task rd(input logic [63:0] a, input logic [31:0] e);
		@(negedge clk);
		ma = a;
		mmio_rd = 1;
		@(negedge clk);
		mmio_rd = 0;
		chk({31'h0, rv}, 32'h1);
		chk(rdat, e);
	endtask
	task push(input logic [63:0] s, d, ch, input logic f, x, l);
		@(negedge clk);
		chk({31'h0, dr}, 32'h1);
		din = '{64'h2000, s, d, ch, f, x, l};
		dv = 1;
		@(negedge clk);
		dv = 0;
	endtask
	task wait_st(input dcsc_state_type s);
		for (i = 0; i < 300 && st !== s; i++)
			@(negedge clk);
		chk({29'h0, st}, {29'h0, s});
	endtask
	task err_case(input logic [63:0] s, d, ch, input logic x, late);
		push(s, d, ch, 0, x, 1);
		wr(OFS_CMD, 32'h1);
		if (late)
			wr(OFS_CMPB, 32'h0001_0000);
		wait_st(ST_HALT);
		chk({31'h0, cerr}, 32'h1);
		snap = n_acc;
		rd(B + OFS_STS, 32'hb);
		repeat (20) @(negedge clk);
		chk(n_acc, snap);
		wr(OFS_CMD, 32'h1);
		rd(B + OFS_STS, 32'hb);
		chk(n_acc, snap);
		wr(OFS_CMD, 32'h20);
		rd(B + OFS_STS, 32'h4);
		chk({31'h0, cerr}, 32'h0);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#(25 * 20000);
		n_mismatch++;
		finish_test;
	end
	initial begin
		rst = 1;
		{cfg_wr, mmio_wr, mmio_rd, dv} = 4'h0;
		ca = 0;
		cd = 0;
		ma = 0;
		wd = 0;
		din = '0;
		repeat (3) @(negedge clk);
		rst = 0;
		ca = CFG_BASE_LO;
		cd = 32'h1000;
		cfg_wr = 1;
		@(negedge clk);
		ca = CFG_BASE_HI;
		cd = 0;
		@(negedge clk);
		cfg_wr = 0;
		rd(B + OFS_STS, 32'h4);
		rd(64'h2000 + OFS_STS, 32'h0);
		rd(B + 8'h40, 32'h0);
		wr(OFS_CMD, 32'h4);
		rd(B + OFS_STS, 32'h3);
		wr(OFS_CMD, 32'h26);
		rd(B + OFS_STS, 32'h4);
		rd(B + OFS_CMD, 32'h2);
		wr(OFS_CMPA, 32'h3000);
		wr(OFS_CMPB, 32'h0);
		rd(B + OFS_CMPA, 32'h3000);
		for (int k = 0; k < 4; k++)
			push(64'h4000 + k * 256, 64'h8000 + k * 256, 0, k == 2, k == 1, k == 3);
		@(negedge clk);
		chk({31'h0, dr}, 32'h0);
		wr(OFS_CMD, 32'h1);
		rd(B + OFS_STS, 32'h0);
		wait_st(ST_IDLE);
		chk(n_stat, 1);
		chk(n_acc, 5);
		chk(n_bad, 0);
		chk(last_a[31:0], 32'h3000);
		chk(last_b[31:0], 32'h2000);
		rd(B + OFS_STS, 32'h1);
		wr(OFS_CMD, 32'h4);
		rd(B + OFS_STS, 32'h3);
		wr(OFS_CMD, 32'h20);
		repeat (10) @(negedge clk);
		err_case(64'h4000, 64'h0001_0000_0000_5000, 0, 1, 0);
		err_case(64'h4000, 64'h5000, 64'h0100_0000_0000_0000, 0, 0);
		wr(OFS_CMPB, 32'h0001_0000);
		err_case(64'h4000, 64'h5000, 0, 0, 0);
		wr(OFS_CMPB, 32'h0);
		err_case(64'h4000, 64'h5000, 0, 0, 1);
		finish_test;
	end
endmodule
`default_nettype wire
